// [shared/dtc_cost_if.sv]
// request and answer of the per-side bus-cycle weight lookup
`timescale 1ns/1ps
`default_nettype none
interface dtc_cost_if;
  import dtc_pkg::*;
  dtc_area_t  area;
  logic [1:0] waits;
  logic       is_write;
  logic [2:0] weight;
  modport user (output area, output waits, output is_write, input weight);
  modport calc (input area, input waits, input is_write, output weight);
endinterface : dtc_cost_if
`default_nettype wire

// [shared/dtc_pkg.sv]
// types for the dma transfer-cycle control block
package dtc_pkg;
  typedef enum logic [1:0] {
    DTC_AREA_INT = 2'h0,
    DTC_AREA_SFR = 2'h1,
    DTC_AREA_EXT = 2'h2
  } dtc_area_t;

  typedef enum logic [2:0] {
    DTC_IDLE  = 3'h0,
    DTC_READ  = 3'h1,
    DTC_WRITE = 3'h3,
    DTC_GAP   = 3'h2
  } dtc_state_t;
endpackage : dtc_pkg

// [shared/dtc_regs.svh]
// constants for the dma transfer-cycle control block
`ifndef DTC_REGS_SVH
`define DTC_REGS_SVH
`define DTC_NCH          4
`define DTC_CNT_W        16
`define DTC_J_INT        3'h1
`define DTC_K_INT        3'h1
`define DTC_J_SFR        3'h2
`define DTC_K_SFR        3'h2
`define DTC_J_EXT0       3'h1
`define DTC_K_EXT0       3'h2
`define DTC_WAIT_BASE    3'h1
`define DTC_CTL_EN_BIT   0
`define DTC_CTL_RQ_BIT   1
`endif

// [verif/dtc_ctrl_monitor.sv]
// port assertions for the dma transfer-cycle control block
`timescale 1ns/1ps
`default_nettype none
module dtc_ctrl_monitor (
  // clock, reset and software writes
  input wire logic       REF_CLK, RESETN, CTL_WR, CTL_EN, CTL_RQ,
  input wire logic [1:0] CTL_CH,
  // requests and status
  input wire logic [3:0] REQ_IN, CH_EN, CH_PEND,
  input wire logic       BUS_BUSY, RD_CYC, WR_CYC,
  input wire logic [1:0] ACT_CH
);
  logic [3:0] req_r;

  always_ff @(posedge REF_CLK)
    req_r <= REQ_IN;

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RESETN);

  // longest phase is eight cycles: two four-weight halves on a split word
  sequence rd_done; ##[1:8] (!RD_CYC && WR_CYC); endsequence
  sequence wr_done; ##[1:8] !WR_CYC; endsequence
  sequence cpu_slot; !RD_CYC [*2]; endsequence

  rw_excl_a: assert property (!(RD_CYC && WR_CYC)) else $error("read and write overlap");
  busy_cover_a: assert property ((RD_CYC || WR_CYC) |-> BUS_BUSY) else $error("cycle without busy");
  read_then_write_a: assert property ($rose(RD_CYC) |-> rd_done) else $error("read phase bad");
  write_bound_a: assert property ($rose(WR_CYC) |-> wr_done) else $error("write phase too long");
  cpu_gap_a: assert property ($fell(WR_CYC) |-> cpu_slot) else $error("no cpu slot");
  chan_prio_a: assert property ($rose(RD_CYC) && $past(CH_EN[0] && CH_PEND[0]) |-> ACT_CH == 2'h0)
    else $error("channel 0 not first");
  start_clear_a: assert property ($rose(RD_CYC) && !req_r[ACT_CH] |-> !CH_PEND[ACT_CH])
    else $error("pending not cleared at start");
  zero_clears_a: assert property (CTL_WR && !CTL_RQ && !REQ_IN[CTL_CH] |=> !CH_PEND[$past(CTL_CH)])
    else $error("pending not cleared by zero");
  one_keeps_a: assert property (CTL_WR && CTL_RQ && !CTL_EN && !CH_EN[CTL_CH] && CH_PEND[CTL_CH]
    |=> CH_PEND[$past(CTL_CH)]) else $error("pending lost on one");
endmodule : dtc_ctrl_monitor
`default_nettype wire

// [verif/dtc_req_src.sv]
// request source standing in for the peripherals that trigger transfers
`timescale 1ns/1ps
`default_nettype none
module dtc_req_src (
  input  wire logic       REF_CLK,
  input  wire logic [3:0] GO,
  output logic [3:0]      REQ_IN
);
  // launched just after the edge so the controller sees a clean one-cycle pulse
  always_ff @(posedge REF_CLK)
    REQ_IN <= GO;
endmodule : dtc_req_src
`default_nettype wire

// [verif/test_dtc_ctrl.sv]
// self-checking bench for the dma transfer-cycle control block
`timescale 1ns/1ps
`default_nettype none
module test_dtc_ctrl;
  logic        clk = 0, rstn = 0, wr = 0, en = 0, rq = 0, ld = 0, ub = 0, b8 = 0, xm = 0, so = 0, dod = 0;
  logic [1:0]  ch = 0, sa = 0, da = 0, wc = 0, act;
  logic [3:0]  go = 0, req, chen, pend;
  logic [15:0] cv = 0, co;
  logic        busy, rd, wrc;
  logic [4:0]  uc;
  int          num_errors = 0, comparisons = 0, cyc = 0;
  int          q[$];
  int          cm[4];
  logic [3:0]  em = 0, pm = 0;

  always #20 clk = ~clk;
  dtc_req_src src (.REF_CLK(clk), .GO(go), .REQ_IN(req));
  dtc_ctrl dut (.REF_CLK(clk), .RESETN(rstn), .CTL_WR(wr), .CTL_CH(ch), .CTL_EN(en), .CTL_RQ(rq),
    .REQ_IN(req), .CNT_LOAD(ld), .CNT_VAL(cv), .UNIT_BYTE(ub), .BUS8(b8), .EXP_MODE(xm), .SRC_ODD(so),
    .DST_ODD(dod), .SRC_AREA(sa), .DST_AREA(da), .WAIT_CFG(wc), .CH_EN(chen), .CH_PEND(pend),
    .BUS_BUSY(busy), .RD_CYC(rd), .WR_CYC(wrc), .ACT_CH(act), .CNT_OUT(co), .UNIT_CYCLES(uc));

  task final_report;
    if (num_errors == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : final_report

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      num_errors++;
      final_report;
    end
  end

  task chk(string n, logic [15:0] e, logic [15:0] s);
    comparisons++;
    if (e !== s)
    begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task wctl(int c, logic e, logic r);
    @(negedge clk);
    {ch, en, rq, wr} = {2'(c), e, r, 1'b1};
    @(negedge clk);
    wr = 0;
  endtask : wctl

  task pulse(logic [3:0] m);
    go = m;
    @(negedge clk);
    go = 0;
    @(negedge clk);
  endtask : pulse

  // weight of one bus cycle by area and external waits
  function int jk(logic [1:0] a, logic [1:0] w, bit isw);
    if (a == 2'h1) return 2;
    if (a != 2'h2) return 1;
    if (w == 2'h0) return isw ? 2 : 1;
    return w + 1;
  endfunction : jk

  task xfer(int c);
    int n, er, ew, nr, nw;
    logic [15:0] v;
    @(negedge clk);
    {ub, b8, xm, so, dod, sa, da, wc} = 11'($urandom);
    v = 16'($urandom_range(65535, 1));
    {ch, cv, ld} = {2'(c), v, 1'b1};
    @(negedge clk);
    ld = 0;
    cm[c] = v;
    wctl(c, 1, 1);
    em[c] = 1'b1;
    chk("count_initial", v, co);
    chk("ch_en", 16'(em), 16'(chen));
    pulse(4'h1 << c);
    pm[c] = 1'b1;
    chk("pend_set", 16'(pm), 16'(pend));
    n = (ub || !(so || dod || (xm && b8))) ? 1 : 2;
    er = jk(sa, wc, 1'b0) * n;
    ew = jk(da, wc, 1'b1) * n;
    nr = 0;
    nw = 0;
    while (!rd) @(negedge clk);
    pm[c] = 1'b0;
    chk("act_ch", 16'(c), 16'(act));
    chk("pending_at_start", 16'(pm), 16'(pend));
    chk("busy", 16'h0001, 16'(busy));
    chk("unit_cycles", 16'(er + ew), 16'(uc));
    while (rd)
    begin
      nr++;
      @(negedge clk);
    end
    while (wrc)
    begin
      nw++;
      @(negedge clk);
    end
    chk("read_cycles", 16'(er), 16'(nr));
    chk("write_cycles", 16'(ew), 16'(nw));
    cm[c] = cm[c] - 1;
    @(negedge clk);
    chk("count_after", 16'(cm[c]), co);
  endtask : xfer

  initial
  begin
    void'($urandom(58572));
    repeat (4) @(negedge clk);
    rstn = 1;
    @(negedge clk);
    chk("reset_status", 16'h0000, 16'({chen, pend, busy, rd, wrc}));
    for (int i = 0; i < 12; i++)
      xfer(i % 4);
    // two requests in one cycle: lower channel first, then the other
    q.push_back(1);
    q.push_back(2);
    pulse(4'h6);
    repeat (2)
    begin
      while (!rd) @(negedge clk);
      chk("prio_order", 16'(q.pop_front()), 16'(act));
      cm[act] = cm[act] - 1;
      while (rd || wrc) @(negedge clk);
    end
    chk("prio_pend", 16'h0000, 16'(pend));
    ch = 2'h2;
    repeat (2) @(negedge clk);
    chk("prio_count", 16'(cm[2]), co);
    wctl(3, 0, 0);
    em[3] = 1'b0;
    pm[3] = 1'b0;
    pulse(4'h8);
    pm[3] = 1'b1;
    chk("pend_disabled", 16'(pm), 16'(pend));
    wctl(3, 0, 1);
    chk("pend_keep", 16'(pm), 16'(pend));
    wctl(3, 0, 0);
    pm[3] = 1'b0;
    chk("pend_clear", 16'(pm), 16'(pend));
    chk("ch_en_off", 16'(em), 16'(chen));
    rstn = 0;
    repeat (2) @(negedge clk);
    rstn = 1;
    em = 4'h0;
    pm = 4'h0;
    @(negedge clk);
    chk("midrun_reset", 16'h0000, 16'({chen, pend, busy, rd, wrc}));
    chk("midrun_count", 16'h0000, co);
    xfer(0);
    final_report;
  end
endmodule : test_dtc_ctrl

bind dtc_ctrl dtc_ctrl_monitor u_mon (.REF_CLK(REF_CLK), .RESETN(RESETN), .CTL_WR(CTL_WR), .CTL_EN(CTL_EN),
  .CTL_RQ(CTL_RQ), .CTL_CH(CTL_CH), .REQ_IN(REQ_IN), .CH_EN(CH_EN), .CH_PEND(CH_PEND), .BUS_BUSY(BUS_BUSY),
  .RD_CYC(RD_CYC), .WR_CYC(WR_CYC), .ACT_CH(ACT_CH));
`default_nettype wire

// [verilog/dtc_cost.sv]
// weight of one read or write bus cycle by target area
`timescale 1ns/1ps
`default_nettype none
`include "dtc_regs.svh"
module dtc_cost
  import dtc_pkg::*;
(
  dtc_cost_if.calc c
);
  wire [2:0] ext_w;
  // waits come from the chip-select wait setting
  assign ext_w = (c.waits == 2'h0) ? (c.is_write ? `DTC_K_EXT0 : `DTC_J_EXT0)
               : (`DTC_WAIT_BASE + {1'b0, c.waits});
  assign c.weight = (c.area == DTC_AREA_SFR) ? (c.is_write ? `DTC_K_SFR : `DTC_J_SFR)
                  : (c.area == DTC_AREA_EXT) ? ext_w
                  : (c.is_write ? `DTC_K_INT : `DTC_J_INT);
endmodule : dtc_cost
`default_nettype wire

// [verilog/dtc_ctrl.sv]
// four-channel dma transfer-cycle accounting and request control
//
// Behaviour
// - byte unit: one read, one write; word: one each only if even on 16-bit bus
// - read weight j, write weight k from area and external wait count
// - external wait count comes from the chip-select wait setting
// - writing one to pending keeps it; writing zero clears it
// - channel 0 first then 1,2,3; one cpu access between channel transfers
// - pending bit clears on the same edge that the channel's transfer starts, unless that channel's request is high in that cycle
// - each unit is a source read cycle then a destination write cycle
// - in expansion modes internal areas also use the bus-width pin width
`timescale 1ns/1ps
`default_nettype none
`include "dtc_regs.svh"
module dtc_ctrl
  import dtc_pkg::*;
(
  // clock and reset
  input  wire logic        REF_CLK,
  input  wire logic        RESETN,
  // software control write
  input  wire logic        CTL_WR,
  input  wire logic [1:0]  CTL_CH,
  input  wire logic        CTL_EN,
  input  wire logic        CTL_RQ,
  // transfer requests and count loading
  input  wire logic [3:0]  REQ_IN,
  input  wire logic        CNT_LOAD,
  input  wire logic [15:0] CNT_VAL,
  // transfer configuration
  input  wire logic        UNIT_BYTE,
  input  wire logic        BUS8,
  input  wire logic        EXP_MODE,
  input  wire logic        SRC_ODD,
  input  wire logic        DST_ODD,
  input  wire logic [1:0]  SRC_AREA,
  input  wire logic [1:0]  DST_AREA,
  input  wire logic [1:0]  WAIT_CFG,
  // status
  output logic [3:0]       CH_EN,
  output logic [3:0]       CH_PEND,
  output logic             BUS_BUSY,
  output logic             RD_CYC,
  output logic             WR_CYC,
  output logic [1:0]       ACT_CH,
  output logic [15:0]      CNT_OUT,
  output logic [4:0]       UNIT_CYCLES
);
  dtc_cost_if cr ();
  dtc_cost_if cw ();

  dtc_state_t  st_r, st_nxt;
  logic [3:0]  en_r, pend_r;
  logic [1:0]  ch_r;
  logic [2:0]  wt_r;
  logic        part_r;
  logic [15:0] cnt_r [`DTC_NCH];
  logic [15:0] cnt_out_r;
  logic [4:0]  ucyc_r;
  logic        busy_r, rd_r, wr_r;

  wire        bus8_eff;
  wire        two_cyc;
  wire [3:0]  ready;
  wire        any_ready;
  wire [1:0]  pick;
  wire [2:0]  rw_w;
  wire [2:0]  ww_w;
  wire [4:0]  unit_total;
  wire        wt_done;
  wire        last_part;

  // bus-width pin only matters outside single-chip mode
  assign bus8_eff  = EXP_MODE & BUS8;
  assign two_cyc   = ~UNIT_BYTE & (bus8_eff | SRC_ODD | DST_ODD);
  assign ready     = en_r & pend_r;
  assign any_ready = |ready;
  assign pick      = ready[0] ? 2'h0 : ready[1] ? 2'h1 : ready[2] ? 2'h2 : 2'h3;

  assign cr.area     = dtc_area_t'(SRC_AREA);
  assign cr.waits    = WAIT_CFG;
  assign cr.is_write = 1'b0;
  assign cw.area     = dtc_area_t'(DST_AREA);
  assign cw.waits    = WAIT_CFG;
  assign cw.is_write = 1'b1;
  assign rw_w        = cr.weight;
  assign ww_w        = cw.weight;

  dtc_cost u_rd (.c(cr.calc));
  dtc_cost u_wr (.c(cw.calc));

  // read cycles x j + write cycles x k
  // widened first so two four-weight halves cannot wrap
  assign unit_total = two_cyc ? ({1'b0, rw_w, 1'b0} + {1'b0, ww_w, 1'b0})
                              : 5'({2'h0, rw_w} + {2'h0, ww_w});
  assign wt_done    = (wt_r == 3'h1);
  assign last_part  = ~two_cyc | part_r;

  always_comb
  begin
    st_nxt = st_r;
    case (st_r)
      DTC_IDLE:  if (any_ready) st_nxt = DTC_READ;
      DTC_READ:  if (wt_done & last_part) st_nxt = DTC_WRITE;
      DTC_WRITE: if (wt_done & last_part) st_nxt = DTC_GAP;
      DTC_GAP:   st_nxt = DTC_IDLE;
      default:   st_nxt = DTC_IDLE;
    endcase
  end

  always_ff @(posedge REF_CLK)
  begin
    if (!RESETN)
    begin
      st_r   <= DTC_IDLE;
      ch_r   <= 2'h0;
      wt_r   <= 3'h0;
      part_r <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      if (st_r == DTC_IDLE && any_ready)
      begin
        ch_r   <= pick;
        wt_r   <= rw_w;
        part_r <= 1'b0;
      end
      else if (st_r == DTC_READ || st_r == DTC_WRITE)
      begin
        if (!wt_done)
          wt_r <= wt_r - 3'h1;
        else if (!last_part)
        begin
          part_r <= 1'b1;
          wt_r   <= (st_r == DTC_READ) ? rw_w : ww_w;
        end
        else
        begin
          part_r <= 1'b0;
          wt_r   <= ww_w;
        end
      end
    end
  end

  // per-channel enable, pending and count
  genvar g;
  generate
    for (g = 0; g < `DTC_NCH; g++)
    begin : g_ch
      wire wr_me = CTL_WR & (CTL_CH == 2'(g));
      wire start = (st_r == DTC_IDLE) & any_ready & (pick == 2'(g));
      wire done  = (st_r == DTC_WRITE) & wt_done & last_part & (ch_r == 2'(g));
      always_ff @(posedge REF_CLK)
      begin
        if (!RESETN)
        begin
          en_r[g]   <= 1'b0;
          pend_r[g] <= 1'b0;
          cnt_r[g]  <= 16'h0000;
        end
        else
        begin
          if (wr_me)
            en_r[g] <= CTL_EN;
          // request wins over a software clear in the same cycle
          if (REQ_IN[g])
            pend_r[g] <= 1'b1;
          else if (start)
            pend_r[g] <= 1'b0;
          else if (wr_me && !CTL_RQ)
            pend_r[g] <= 1'b0;
          if (CNT_LOAD && CTL_CH == 2'(g))
            cnt_r[g] <= CNT_VAL;
          else if (done)
            cnt_r[g] <= cnt_r[g] - 16'h0001;
        end
      end
    end
  endgenerate

  always_ff @(posedge REF_CLK)
  begin
    if (!RESETN)
    begin
      busy_r    <= 1'b0;
      rd_r      <= 1'b0;
      wr_r      <= 1'b0;
      cnt_out_r <= 16'h0000;
      ucyc_r    <= 5'h00;
    end
    else
    begin
      busy_r    <= (st_nxt == DTC_READ) | (st_nxt == DTC_WRITE);
      rd_r      <= (st_nxt == DTC_READ);
      wr_r      <= (st_nxt == DTC_WRITE);
      // readback lets software check for the initial state after enabling
      cnt_out_r <= cnt_r[CTL_CH];
      ucyc_r    <= unit_total;
    end
  end

  assign CH_EN       = en_r;
  assign CH_PEND     = pend_r;
  assign BUS_BUSY    = busy_r;
  assign RD_CYC      = rd_r;
  assign WR_CYC      = wr_r;
  assign ACT_CH      = ch_r;
  assign CNT_OUT     = cnt_out_r;
  assign UNIT_CYCLES = ucyc_r;
endmodule : dtc_ctrl
`default_nettype wire
